// File: rtl/reset_source_sequencer.sv
// Reset source sequencer: cause capture, reset pin timing, cause register over APB
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "rss_regs.svh"
module reset_source_sequencer (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`RSS_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Shared open-drain reset pin
  input  wire logic                    rst_pin_in,
  output logic                         rst_pin_out,
  output logic                         rst_pin_oe_n,
  // Analog supply indications
  input  wire logic                    power_on_pulse,
  input  wire logic                    supply_low,
  // Core side
  input  wire rss_pkg::cpu_events_s    cpu_ev,
  input  wire logic                    cpu_wr,
  input  wire logic [15:0]             cpu_addr,
  output logic                         watchdog_clear,
  output logic                         abort_instr,
  output logic                         core_reset,
  output logic                         clocks_held,
  output logic                         bus_clk_en,
  output logic                         vector_fetch,
  output logic [15:0]                  vector_addr,
  // Interrupt
  output logic                         irq
);

  // Synchronised pins
  logic [2:0]               pins_s;           // {por, supply, reset pin}
  logic                     por_s;            // Power-on pulse
  logic                     lvi_s;            // Supply below rising threshold
  logic                     pin_s;            // Reset pin level
  // Sequencer
  rss_pkg::seq_state_e      state_q;          // Current phase
  rss_pkg::seq_state_e      state_d;          // Next phase
  logic                     tmr_load;         // Start timing a new phase
  logic [`RSS_TMR_W-1:0]    tmr_val;          // Length of new phase minus one
  logic                     tmr_done;         // Phase time elapsed
  logic [1:0]               ext_cnt_q;        // Consecutive low pin samples
  logic                     ext_hit;          // Pin low long enough
  logic [1:0]               div_q;            // Bus clock divider
  // Causes and registers
  rss_pkg::cause_t          cause_set;        // Flags raised this cycle
  rss_pkg::cause_t          cause_q;          // Reset cause register
  rss_pkg::cause_t          irq_stat_q;       // Sticky interrupt status
  rss_pkg::cause_t          irq_mask_q;       // Interrupt mask
  logic [7:0]               config_q;         // Option configuration one
  logic                     halt_bad;         // Halt without permit
  logic                     int_cause;        // Any internal core cause
  logic                     reset_start;      // A reset begins this cycle
  // APB decode
  logic                     apb_acc;          // Access phase completes
  logic                     apb_wr;           // Write completes
  logic                     apb_rd;           // Read completes
  logic                     hit_cause;        // Cause register addressed
  logic                     hit_cfg;          // Config register addressed
  logic                     hit_stat;         // Interrupt status addressed
  logic                     hit_mask;         // Interrupt mask addressed

  // Reset pin, supply and power-on pulse cross in here
  rss_sync2 u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({~power_on_pulse, ~supply_low, rst_pin_in}),
    .sync_out (pins_s)
  );

  assign por_s = ~pins_s[2];
  assign lvi_s = ~pins_s[1];
  assign pin_s = pins_s[0];

  // Phase timer
  rss_timer u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // Core causes, halt trapped unless permitted
  assign halt_bad  = cpu_ev.halt_exec & ~config_q[`RSS_HALT_PERMIT_BIT];
  // Unmapped data reads are not a cause
  assign int_cause = cpu_ev.watchdog_overflow | cpu_ev.illegal_opcode | halt_bad |
                     cpu_ev.fetch_unmapped | cpu_ev.monitor_entry;

  // External low pin filter, counted in run only so own drive never trips it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt_q <= 2'h0;
    end else if (state_q != rss_pkg::ST_RUN || pin_s) begin
      ext_cnt_q <= 2'h0;
    end else if (!ext_hit) begin
      ext_cnt_q <= ext_cnt_q + 2'h1;
    end
  end

  assign ext_hit = (ext_cnt_q >= 2'(`RSS_MIN_RST_LOW_CYC - 1)) && !pin_s &&
                   (state_q == rss_pkg::ST_RUN);

  // Next phase; power-on beats supply drop beats core causes beats the pin
  always_comb begin
    state_d = state_q;
    if (por_s || lvi_s) begin
      state_d = rss_pkg::ST_SUPPLY_WAIT;
    end else begin
      unique case (state_q)
        rss_pkg::ST_RUN: begin
          if (int_cause) begin
            state_d = rss_pkg::ST_PIN_LOW;
          end else if (ext_hit) begin
            state_d = rss_pkg::ST_EXT_LOW;
          end
        end
        rss_pkg::ST_SUPPLY_WAIT: state_d = rss_pkg::ST_STAB;
        rss_pkg::ST_STAB: begin
          if (tmr_done) begin
            state_d = rss_pkg::ST_PIN_LOW;
          end
        end
        rss_pkg::ST_PIN_LOW: begin
          if (tmr_done) begin
            state_d = rss_pkg::ST_CORE_HOLD;
          end
        end
        rss_pkg::ST_CORE_HOLD: begin
          if (tmr_done) begin
            state_d = rss_pkg::ST_RUN;
          end
        end
        rss_pkg::ST_EXT_LOW: begin
          if (pin_s) begin
            state_d = rss_pkg::ST_CORE_HOLD;
          end
        end
        default: state_d = rss_pkg::ST_SUPPLY_WAIT;
      endcase
    end
  end

  // Phase lengths, loaded as the phase is entered
  always_comb begin
    tmr_load = (state_d != state_q);
    unique case (state_d)
      rss_pkg::ST_STAB:      tmr_val = `RSS_TMR_W'(`RSS_STAB_CYC - 1);
      rss_pkg::ST_PIN_LOW:   tmr_val = `RSS_TMR_W'(`RSS_PIN_LOW_CYC - 1);
      rss_pkg::ST_CORE_HOLD: tmr_val = `RSS_TMR_W'(`RSS_CORE_HOLD_CYC - 1);
      default:               tmr_val = '0;
    endcase
  end

  // Phase register; the first cycle after reset release enters power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rss_pkg::ST_SUPPLY_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Reset begins whenever the core leaves run or power fails again
  assign reset_start = (state_q == rss_pkg::ST_RUN && state_d != rss_pkg::ST_RUN) ||
                       ((por_s || lvi_s) && state_q != rss_pkg::ST_SUPPLY_WAIT);

  // Pin driven low in supply wait, stabilization and pin-low phases
  assign rst_pin_out  = 1'b0;
  assign rst_pin_oe_n = !(state_q == rss_pkg::ST_SUPPLY_WAIT ||
                          state_q == rss_pkg::ST_STAB ||
                          state_q == rss_pkg::ST_PIN_LOW);
  assign core_reset   = (state_q != rss_pkg::ST_RUN);
  assign clocks_held  = (state_q == rss_pkg::ST_SUPPLY_WAIT ||
                         state_q == rss_pkg::ST_STAB);
  assign abort_instr  = reset_start;

  // Bus clock divider restarts at every reset, stopped while clocks held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
    end else if (reset_start || clocks_held) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  assign bus_clk_en = (div_q == `RSS_BUS_DIV_LAST);

  // Vector fetch pulse when the core leaves reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_fetch <= 1'b0;
      vector_addr  <= `RSS_VECTOR_ADDR;
    end else begin
      vector_fetch <= (state_q == rss_pkg::ST_CORE_HOLD && state_d == rss_pkg::ST_RUN);
      vector_addr  <= `RSS_VECTOR_ADDR;
    end
  end

  // Watchdog restart on any core write to its location while the core is out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= cpu_wr && (cpu_addr == `RSS_WDOG_ADDR) && !core_reset;
    end
  end

  // Flags raised this cycle, by cause
  always_comb begin
    cause_set = '0;
    if (state_q == rss_pkg::ST_RUN && !(por_s || lvi_s)) begin
      cause_set[`RSS_WDOG_BIT]   = cpu_ev.watchdog_overflow;
      cause_set[`RSS_BADOP_BIT]  = cpu_ev.illegal_opcode | halt_bad;
      cause_set[`RSS_BADADR_BIT] = cpu_ev.fetch_unmapped;
      cause_set[`RSS_MON_BIT]    = cpu_ev.monitor_entry;
      cause_set[`RSS_PIN_BIT]    = ext_hit & ~int_cause;
    end
    if (lvi_s && !por_s && state_q != rss_pkg::ST_SUPPLY_WAIT) begin
      cause_set[`RSS_LVI_BIT] = 1'b1;
    end
    if (state_q == rss_pkg::ST_CORE_HOLD && tmr_done && !pin_s) begin
      cause_set[`RSS_PIN_BIT] = 1'b1;
    end
  end

  // APB decode, zero wait states
  assign apb_acc   = psel && penable;
  assign apb_wr    = apb_acc && pwrite;
  assign apb_rd    = apb_acc && !pwrite;
  assign hit_cause = (paddr == `RSS_CAUSE_OFF);
  assign hit_cfg   = (paddr == `RSS_CONFIG_OFF);
  assign hit_stat  = (paddr == `RSS_IRQ_STAT_OFF);
  assign hit_mask  = (paddr == `RSS_IRQ_MASK_OFF);
  assign pready    = 1'b1;
  assign pslverr   = apb_acc && !(hit_cfg || hit_stat || hit_mask || (hit_cause && !pwrite));

  // Cause register: power-on clears others, a read clears only what it reported,
  // so a flag raised during the setup cycle is not lost unseen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= `RSS_CAUSE_RESET;
    end else if (por_s) begin
      cause_q <= `RSS_POR_ONLY;
    end else if (apb_rd && hit_cause) begin
      cause_q <= (cause_q & ~{prdata[7:1], 1'b0}) | cause_set;
    end else begin
      cause_q <= cause_q | cause_set;
    end
  end

  // Option configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= `RSS_CONFIG_RESET;
    end else if (apb_wr && hit_cfg) begin
      config_q <= pwdata[7:0];
    end
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (apb_wr && hit_stat) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[7:0]) | cause_set;
    end else begin
      irq_stat_q <= irq_stat_q | cause_set;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (apb_wr && hit_mask) begin
      irq_mask_q <= pwdata[7:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read data, upper bits zero, bit0 zero for the cause register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (hit_cause) begin
        prdata[7:1] <= cause_q[7:1];
      end else if (hit_cfg) begin
        prdata[7:0] <= config_q;
      end else if (hit_stat) begin
        prdata[7:0] <= irq_stat_q;
      end else if (hit_mask) begin
        prdata[7:0] <= irq_mask_q;
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [12:0] age_q;  // Cycles spent in the current phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= '0;
    end else if (state_d != state_q) begin
      age_q <= '0;
    end else if (age_q != 13'h1FFF) begin
      age_q <= age_q + 13'h1;
    end
  end

  sequence pin_phase_end_s;
    state_q == rss_pkg::ST_PIN_LOW ##1 state_q == rss_pkg::ST_CORE_HOLD;
  endsequence
  sequence hold_phase_end_s;
    state_q == rss_pkg::ST_CORE_HOLD ##1 state_q == rss_pkg::ST_RUN;
  endsequence

  pin_low_len_a: assert property (pin_phase_end_s |-> $past(age_q) == 13'd31)
    else $error("pin low phase not 32 cycles");
  core_hold_len_a: assert property (hold_phase_end_s |-> $past(age_q) == 13'd31)
    else $error("core hold phase not 32 cycles");
  stab_len_a: assert property (state_q == rss_pkg::ST_STAB ##1
                               state_q == rss_pkg::ST_PIN_LOW |-> $past(age_q) == 13'd4095)
    else $error("stabilization not 4096 cycles");
  stab_pin_low_a: assert property (clocks_held |-> !rst_pin_oe_n && core_reset)
    else $error("pin released while clocks held");
  vector_fetch_a: assert property (hold_phase_end_s |-> vector_fetch &&
                                   vector_addr == `RSS_VECTOR_ADDR)
    else $error("vector fetch missing at reset exit");
  bus_div_a: assert property (abort_instr |=> !bus_clk_en [*3])
    else $error("bus clock not restarted at reset");
  por_flags_a: assert property (por_s |=> cause_q == `RSS_POR_ONLY)
    else $error("power-on did not leave only its flag");
  read_clear_a: assert property (apb_rd && hit_cause && !por_s |=>
                                 (cause_q & $past(prdata[7:0] & ~cause_set)) == 8'h00)
    else $error("cause read did not clear flags");
  flags_keep_a: assert property ($fell(cause_q[`RSS_WDOG_BIT]) |->
                                 $past(apb_rd && hit_cause) || $past(por_s))
    else $error("flag lost without read");
  halt_trap_a: assert property (state_q == rss_pkg::ST_RUN && !por_s && !lvi_s &&
                                cpu_ev.halt_exec && !config_q[`RSS_HALT_PERMIT_BIT] |=>
                                state_q == rss_pkg::ST_PIN_LOW && cause_q[`RSS_BADOP_BIT])
    else $error("halt without permit not trapped");
  data_read_a: assert property (state_q == rss_pkg::ST_RUN && !por_s && !lvi_s && !int_cause &&
                                !ext_hit && cpu_ev.data_read_unmapped |=>
                                state_q == rss_pkg::ST_RUN)
    else $error("unmapped data read caused reset");
  wdog_clear_a: assert property (cpu_wr && cpu_addr == `RSS_WDOG_ADDR && !core_reset |=>
                                 watchdog_clear)
    else $error("watchdog write did not clear");

endmodule

// File: rtl/rss_pkg.sv
// Types shared by the reset sequencer files
package rss_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SUPPLY_WAIT,
    ST_STAB,
    ST_PIN_LOW,
    ST_CORE_HOLD,
    ST_EXT_LOW
  } seq_state_e;

  // Events from the core, all on the reference clock; all but data_read_unmapped are reset causes, halt_exec only without halt permit
  typedef struct packed {
    logic watchdog_overflow;
    logic illegal_opcode;
    logic halt_exec;
    logic fetch_unmapped;
    logic data_read_unmapped;
    logic monitor_entry;
  } cpu_events_s;

  // Eight-bit cause layout
  typedef logic [7:0] cause_t;

endpackage

// File: rtl/rss_regs.svh
// Register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// APB register byte offsets
`define RSS_ADDR_W          12
`define RSS_CAUSE_OFF       12'h000
`define RSS_CONFIG_OFF      12'h004
`define RSS_IRQ_STAT_OFF    12'h008
`define RSS_IRQ_MASK_OFF    12'h00C

// Cause flag positions, shared by cause, interrupt status and mask
`define RSS_POR_BIT         7
`define RSS_PIN_BIT         6
`define RSS_WDOG_BIT        5
`define RSS_BADOP_BIT       4
`define RSS_BADADR_BIT      3
`define RSS_MON_BIT         2
`define RSS_LVI_BIT         1
`define RSS_CAUSE_RESET     8'h80
`define RSS_POR_ONLY        8'h80

// Option configuration: halt permit bit
`define RSS_HALT_PERMIT_BIT 0
`define RSS_CONFIG_RESET    8'h00

// CPU address map points
`define RSS_WDOG_ADDR       16'hFFFF
`define RSS_VECTOR_ADDR     16'hFFFE

// Timing, in ns and in reference clock cycles
`define RSS_PCLK_PERIOD_NS  50
`define RSS_MIN_RST_LOW_NS  100
`define RSS_MIN_RST_LOW_CYC ((`RSS_MIN_RST_LOW_NS + `RSS_PCLK_PERIOD_NS - 1) / `RSS_PCLK_PERIOD_NS)
`define RSS_STAB_CYC        4096
`define RSS_PIN_LOW_CYC     32
`define RSS_CORE_HOLD_CYC   32
`define RSS_BUS_DIV_LAST    2'h3
`define RSS_TMR_W           13

`endif

// File: rtl/rss_sync2.sv
// Two-flop synchroniser for the asynchronous reset-related pins
`timescale 1ns/1ps
module rss_sync2 (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pins in, synchronised levels out
  input  wire logic [2:0] async_in,
  output logic      [2:0] sync_out
);

  logic [2:0] meta_q;  // First stage, read only by second stage

  // Both stages idle high, like released reset lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= 3'h7;
      sync_out <= 3'h7;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: rtl/rss_timer.sv
// Down counter timing each sequencer phase
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_timer (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Load and status
  input  wire logic                   load,
  input  wire logic [`RSS_TMR_W-1:0]  load_val,
  output logic                        done
);

  logic [`RSS_TMR_W-1:0] cnt_q;  // Remaining cycles minus one

  // Load wins, otherwise count down to zero and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - `RSS_TMR_W'(1);
    end
  end

  // Phase ends in the cycle the count sits at zero
  assign done = (cnt_q == '0);

endmodule

// File: test/rss_pin_partner.sv
// Far-side device sharing the open-drain reset line, with the line's pull-up
`timescale 1ns/1ps
module rss_pin_partner (
  // Device side of the line
  input  wire logic dev_oe_n,
  // Far-side device pulling the line low
  input  wire logic ext_pull,
  // Resolved line level
  output logic      pin_level
);
  // Any party pulling wins, otherwise the pull-up lifts the line
  assign pin_level = (!dev_oe_n || ext_pull) ? 1'b0 : 1'b1;
endmodule

// File: test/test_reset_source_sequencer.sv
// Self-checking bench of the reset source sequencer
`timescale 1ns/1ps
`include "rss_regs.svh"
module test_reset_source_sequencer;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, r;
  logic                 rst_pin_in, rst_pin_out, rst_pin_oe_n, ext_pull, e;
  logic                 power_on_pulse, supply_low, cpu_wr, irq, abort_instr;
  logic                 watchdog_clear, core_reset, clocks_held, bus_clk_en, vector_fetch;
  logic [15:0]          cpu_addr, vector_addr;
  rss_pkg::cpu_events_s cpu_ev;
  logic [5:0]           evt [5];   // Core reset events, one bit each
  logic [7:0]           acc;       // Expected accumulated cause flags
  int                   n_errors, check_count, n, lo, hi, k, s;

  reset_source_sequencer i_reset_source_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .power_on_pulse, .supply_low,
    .cpu_ev, .cpu_wr, .cpu_addr, .watchdog_clear, .abort_instr, .core_reset,
    .clocks_held, .bus_clk_en, .vector_fetch, .vector_addr, .irq);
  rss_pin_partner i_rss_pin_partner (.dev_oe_n(rst_pin_oe_n), .ext_pull(ext_pull),
    .pin_level(rst_pin_in));

  // 20 MHz reference clock
  always #25 pclk = ~pclk;

  // Value compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Cycle count compare
  task chk_cnt(input int got, input int exp);
    chk(32'(got), 32'(exp));
  endtask

  // Verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; read data and error land in r and e
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) begin
      chk(32'h0000_0000, 32'h0000_0001);
      finish_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cause flags expected from a core event word, from the cause rules
  function automatic logic [7:0] cause_of(input logic [5:0] ev, input logic permit);
    cause_of = 8'h00;
    cause_of[`RSS_WDOG_BIT] = ev[5];
    cause_of[`RSS_BADOP_BIT] = ev[4] || (ev[3] && !permit);
    cause_of[`RSS_BADADR_BIT] = ev[2];
    cause_of[`RSS_MON_BIT] = ev[0];
  endfunction

  // Counts pin-low cycles and core-reset cycles (pin low plus core hold) up to the vector fetch
  // With from_now set, the cycle already sampled at this falling edge counts too
  task seq_count(input logic from_now);
    lo = 0;
    hi = 0;
    n = 0;
    if (from_now) begin
      n++;
      if (rst_pin_oe_n === 1'b0) lo++;
      if (core_reset === 1'b1) hi++;
    end
    while (vector_fetch !== 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
      if (rst_pin_oe_n === 1'b0) lo++;
      if (core_reset === 1'b1) hi++;
    end
    if (n >= 300) begin
      chk_cnt(n, 0);
      finish_test;
    end
  endtask

  // Stabilization hold, then release timing, after power-on or supply drop
  task power_seq;
    n = 0;
    hi = 0;
    while (clocks_held === 1'b1 && n < 5000) begin
      @(negedge pclk);
      n++;
      if (rst_pin_oe_n !== 1'b0) hi++;
    end
    chk_cnt(int'(n >= 4096 && n <= 4102), 1);
    chk_cnt(hi, 0);
    seq_count(1'b1);
    chk_cnt(lo, 32);
    chk_cnt(hi, 64);
    chk(vector_addr, `RSS_VECTOR_ADDR);
  endtask

  // Internal reset from one core event
  task int_reset(input logic [5:0] ev);
    @(posedge pclk);
    cpu_ev <= ev;
    @(negedge pclk);
    chk(abort_instr, 32'h0000_0001);
    @(posedge pclk);
    cpu_ev <= 6'h00;
    seq_count(1'b0);
    chk_cnt(lo, 32);
    chk_cnt(hi, 64);
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    power_on_pulse = 0; supply_low = 0; cpu_ev = 6'h00; cpu_wr = 0; cpu_addr = 0;
    ext_pull = 0; n_errors = 0; check_count = 0;
    evt = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h01};
    s = $urandom(32'ha849586e);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    power_seq;
    apb(1'b0, `RSS_CAUSE_OFF, 32'h0);
    chk(r, 32'h0000_0080);
    apb(1'b0, `RSS_CAUSE_OFF, 32'h0);
    chk(r, 32'h0000_0000);
    apb(1'b1, `RSS_CAUSE_OFF, 32'hFFFF_FFFF);
    chk(e, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0);
    chk({r[30:0], e}, 32'h0000_0001);
    $display("test boot done");
    k = 0;
    repeat (40) begin
      @(negedge pclk);
      if (bus_clk_en === 1'b1) k++;
    end
    chk_cnt(k, 10);
    // Core events in a random rotation, flags accumulate unread
    s = $urandom_range(4, 0);
    acc = 8'h00;
    for (k = 0; k < 5; k++) begin
      int_reset(evt[(k + s) % 5]);
      acc = acc | cause_of(evt[(k + s) % 5], 1'b0);
    end
    chk(irq, 32'h0000_0000);
    apb(1'b0, `RSS_CAUSE_OFF, 32'h0);
    chk(r, {24'h0, acc});
    apb(1'b1, `RSS_IRQ_MASK_OFF, {$urandom() & 32'hFFFF_FF00} | 32'h20);
    @(negedge pclk);
    chk(irq, 32'h0000_0001);
    apb(1'b1, `RSS_IRQ_STAT_OFF, 32'h0000_0020);
    @(negedge pclk);
    chk(irq, 32'h0000_0000);
    apb(1'b0, `RSS_IRQ_STAT_OFF, 32'h0);
    chk(r, {24'h0, acc & 8'hDF});
    $display("test core events done");
    // Halt with permit set and an unmapped data read cause no reset
    apb(1'b1, `RSS_CONFIG_OFF, 32'h0000_0001);
    @(posedge pclk);
    cpu_ev <= 6'h0A;
    @(posedge pclk);
    cpu_ev <= 6'h00;
    hi = 0;
    repeat (40) begin
      @(negedge pclk);
      if (core_reset !== 1'b0) hi++;
    end
    chk_cnt(hi, 0);
    apb(1'b1, `RSS_CONFIG_OFF, 32'h0);
    // Core write to the watchdog location, then elsewhere
    @(posedge pclk);
    cpu_wr <= 1'b1;
    cpu_addr <= `RSS_WDOG_ADDR;
    @(posedge pclk);
    cpu_addr <= 16'($urandom_range(16'hFFFE, 0));
    @(negedge pclk);
    chk(watchdog_clear, 32'h0000_0001);
    @(posedge pclk);
    cpu_wr <= 1'b0;
    @(negedge pclk);
    chk(watchdog_clear, 32'h0000_0000);
    $display("test watchdog done");
    // Far-side device pulls the line
    @(posedge pclk);
    ext_pull <= 1'b1;
    repeat ($urandom_range(10, 4)) @(posedge pclk);
    ext_pull <= 1'b0;
    seq_count(1'b0);
    apb(1'b0, `RSS_CAUSE_OFF, 32'h0);
    chk(r, 32'h0000_0040);
    // Supply drop
    @(posedge pclk);
    supply_low <= 1'b1;
    repeat (20) @(posedge pclk);
    supply_low <= 1'b0;
    @(negedge pclk);
    chk({clocks_held, rst_pin_oe_n}, 32'h0000_0002);
    power_seq;
    apb(1'b0, `RSS_CAUSE_OFF, 32'h0);
    chk(r, 32'h0000_0002);
    $display("test pin and supply done");
    // Far side still holds the line at the last core hold cycle, lets go before run
    s = $urandom_range(4, 0);
    @(posedge pclk);
    cpu_ev <= evt[s];
    @(posedge pclk);
    cpu_ev <= 6'h00;
    ext_pull <= 1'b1;
    repeat (62) @(posedge pclk);
    ext_pull <= 1'b0;
    seq_count(1'b0);
    apb(1'b0, `RSS_CAUSE_OFF, 32'h0);
    chk(r, {24'h0, cause_of(evt[s], 1'b0) | 8'h40});
    // Power-on pulse over a pending watchdog flag
    int_reset(6'h20);
    @(posedge pclk);
    power_on_pulse <= 1'b1;
    repeat (5) @(posedge pclk);
    power_on_pulse <= 1'b0;
    power_seq;
    apb(1'b0, `RSS_CAUSE_OFF, 32'h0);
    chk(r, 32'h0000_0080);
    $display("test late pin and power-on done");
    finish_test;
  end
endmodule
